// ---- src/imucfg_pkg.sv ----
// Package with register indices, field layouts and reset values of the sensor config bank
package imucfg_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_SAMPLE_PORT   = 8'h18;
    localparam logic [7:0] IDX_TEMP_CTRL     = 8'h20;
    localparam logic [7:0] IDX_ROOM_TEMP_LO  = 8'h21;
    localparam logic [7:0] IDX_ACC_MODE      = 8'h22;
    localparam logic [7:0] IDX_ACC_RATE      = 8'h23;
    localparam logic [7:0] IDX_ACC_RANGE     = 8'h25;
    localparam logic [7:0] IDX_ACC_LOWPASS   = 8'h26;
    localparam logic [7:0] IDX_GYRO_MODE     = 8'h28;
    localparam logic [7:0] IDX_GYRO_RATE     = 8'h29;
    localparam logic [7:0] IDX_GYRO_LOWPASS  = 8'h2b;
    localparam logic [7:0] IDX_GYRO_FS_X     = 8'h8f;
    localparam logic [7:0] IDX_GYRO_FS_Y     = 8'h9f;
    localparam logic [7:0] IDX_GYRO_FS_Z     = 8'haf;
    localparam logic [7:0] IDX_TEMP_ANALOG   = 8'hd5;
    localparam logic [7:0] IDX_BANK_STATUS   = 8'hf0;

    // ------------------------------------------------------------
    // Storage slots of the writable registers, and slot codes of the read-only and unmapped ones
    // ------------------------------------------------------------
    localparam int         NUM_CFG           = 13;
    localparam logic [3:0] SLOT_SAMPLE       = 4'hd;
    localparam logic [3:0] SLOT_STATUS       = 4'he;
    localparam logic [3:0] SLOT_NONE         = 4'hf;

    localparam logic [7:0] CFG_IDX  [NUM_CFG] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h25, 8'h26,
                                                  8'h28, 8'h29, 8'h2b, 8'h8f, 8'h9f, 8'haf,
                                                  8'hd5};
    // Writable bits; reserved bits are never stored and read as zero
    localparam logic [7:0] CFG_MASK [NUM_CFG] = '{8'hbf, 8'hff, 8'hc1, 8'h0f, 8'h07, 8'he8,
                                                  8'h11, 8'h0f, 8'h1c, 8'h07, 8'h07, 8'h07,
                                                  8'h04};
    localparam logic [7:0] CFG_RST  [NUM_CFG] = '{8'hb0, 8'h00, 8'h01, 8'h00, 8'h02, 8'h20,
                                                  8'h01, 8'h00, 8'h00, 8'h06, 8'h06, 8'h06,
                                                  8'h04};

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TEMP_EN_BIT      = 7;
    localparam int TEMP_ODR_LSB     = 4;
    localparam int ANALOG_OFF_BIT   = 2;
    localparam int ACC_LP_BIT       = 7;
    localparam int ACC_DITHER_BIT   = 6;
    localparam int ACC_FILT_BIT     = 0;
    localparam int ACC_CUT_LSB      = 5;
    localparam int ACC_BYP_BIT      = 3;
    localparam int GYRO_INACT_BIT   = 4;
    localparam int GYRO_FILT_BIT    = 0;
    localparam int GYRO_BYP_BIT     = 4;
    localparam int GYRO_CUT_LSB     = 2;
    localparam int STAT_GYRO_OFF    = 0;
    localparam int STAT_Q_EMPTY     = 1;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Decoded configuration handed to the sensor paths
    typedef struct packed {
        logic        temp_dig_en;
        logic [1:0]  temp_odr;
        logic [11:0] room_temp;
        logic        temp_ana_en;
        logic        acc_low_power;
        logic        acc_dither;
        logic        acc_filt_en;
        logic [3:0]  acc_odr;
        logic [2:0]  acc_range;
        logic [2:0]  acc_lpf_cut;
        logic        acc_lpf_bypass;
        logic        gyro_inact_off_en;
        logic        gyro_filt_en;
        logic [3:0]  gyro_odr;
        logic        gyro_lpf_bypass;
        logic [1:0]  gyro_lpf_cut;
        logic [2:0]  gyro_fs_x;
        logic [2:0]  gyro_fs_y;
        logic [2:0]  gyro_fs_z;
    } imucfg_cfg_t;

endpackage

// ---- src/imucfg_sample_queue.sv ----
// Byte queue holding buffered samples until the host reads them
`timescale 1ns/100ps
module imucfg_sample_queue #(
    parameter int DEPTH = 16
) (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       in_valid,
    input  wire logic [7:0] in_data,
    output logic            in_ready,
    input  wire logic       pop,
    output logic [7:0]      head,
    output logic            empty
);
    localparam int AW = $clog2(DEPTH);

    logic [7:0]  mem_r [DEPTH];
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic [AW-1:0] rd_r;
    logic [AW-1:0] rd_nxt;
    logic [AW-1:0] wr_r;
    logic [AW-1:0] wr_nxt;
    logic        push;
    logic        take;

    // Full stalls the producer; a pop frees room only on the next cycle
    assign in_ready = (cnt_r != DEPTH[AW:0]);
    assign empty    = (cnt_r == '0);
    assign head     = mem_r[rd_r];
    assign push     = in_valid && in_ready;
    assign take     = pop && !empty;

    // ------------------------------------------------------------
    // Pointer and count update
    // ------------------------------------------------------------
    always_comb begin
        wr_nxt  = push ? AW'(wr_r + 1'b1) : wr_r;
        rd_nxt  = take ? AW'(rd_r + 1'b1) : rd_r;
        cnt_nxt = cnt_r;
        if (push && !take) begin
            cnt_nxt = (AW+1)'(cnt_r + 1'b1);
        end else if (take && !push) begin
            cnt_nxt = (AW+1)'(cnt_r - 1'b1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cnt_r <= '0;
            rd_r  <= '0;
            wr_r  <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            rd_r  <= rd_nxt;
            wr_r  <= wr_nxt;
        end
    end

    // Storage needs no reset; empty guards every read
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end
endmodule

// ---- src/imucfg_regs.sv ----
// Sensor configuration register bank behind an AXI4-Lite slave
// How it works
// - Sample port is read only, writes ignored
// - Temp control bit 7 enables digital path
// - Temp rate field bits 5:4, reset 11
// - Twelve-bit room temperature split across two bytes
// - Analog temp bit 2 inverted, resets disabled
// - Accel bit 7 selects low-power mode
// - Accel bit 6 enables converter dither
// - Accel bit 0 enables filter, reset on
// - Accel rate field four bits, reset 0000
// - Accel range field three bits, reset 010
// - Accel cut-off bits 7:5, reset 001
// - Accel bit 3 bypasses low-pass filter
// - Gyro powers down on inactivity when enabled
// - Gyro bit 0 enables filter, reset on
// - Gyro rate field four bits, reset 0000
// - Gyro bit 4 bypasses low-pass filter
// - Gyro cut-off field bits 3:2
// - Per-axis gyro full scale, reset 110
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
module imucfg_regs #(
    parameter int Q_DEPTH = 16
) (
    input  wire logic                 core_clk,
    input  wire logic                 resetn,
    input  wire logic [11:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [11:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 sample_valid,
    input  wire logic [7:0]           sample_data,
    output logic                      sample_ready,
    input  wire logic                 inactivity_evt,
    output logic                      gyro_power_down,
    output imucfg_pkg::imucfg_cfg_t   cfg
);
    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Maps a byte address onto a storage slot; misaligned is unmapped
    function automatic logic [3:0] slot_of(input logic [11:0] addr);
        logic [3:0] s;
        s = imucfg_pkg::SLOT_NONE;
        if (addr[1:0] != 2'b00 || addr[11:10] != 2'b00) begin
            s = imucfg_pkg::SLOT_NONE;
        end else if (addr[9:2] == imucfg_pkg::IDX_SAMPLE_PORT) begin
            s = imucfg_pkg::SLOT_SAMPLE;
        end else if (addr[9:2] == imucfg_pkg::IDX_BANK_STATUS) begin
            s = imucfg_pkg::SLOT_STATUS;
        end else begin
            for (int i = 0; i < imucfg_pkg::NUM_CFG; i++) begin
                if (addr[9:2] == imucfg_pkg::CFG_IDX[i]) begin
                    s = 4'(i);
                end
            end
        end
        return s;
    endfunction

    logic [7:0]  cfg_r [imucfg_pkg::NUM_CFG];
    logic [7:0]  cfg_nxt [imucfg_pkg::NUM_CFG];
    logic        aw_held_r;
    logic        aw_held_nxt;
    logic [11:0] aw_addr_r;
    logic [11:0] aw_addr_nxt;
    logic        w_held_r;
    logic        w_held_nxt;
    logic [7:0]  w_byte_r;
    logic [7:0]  w_byte_nxt;
    logic        w_lane_r;
    logic        w_lane_nxt;
    logic        bvalid_r;
    logic        bvalid_nxt;
    logic [1:0]  bresp_r;
    logic [1:0]  bresp_nxt;
    logic        rvalid_r;
    logic        rvalid_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0]  rresp_r;
    logic [1:0]  rresp_nxt;
    logic        gyro_off_r;
    logic        gyro_off_nxt;
    logic        aw_hs;
    logic        w_hs;
    logic        ar_hs;
    logic        wr_go;
    logic [3:0]  wr_slot;
    logic [7:0]  wr_data;
    logic        wr_lane;
    logic [3:0]  rd_slot;
    logic        q_pop;
    logic [7:0]  q_head;
    logic        q_empty;

    // Channels refuse new items while a response is still pending
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    assign aw_hs   = s_axi_awvalid && s_axi_awready;
    assign w_hs    = s_axi_wvalid && s_axi_wready;
    assign ar_hs   = s_axi_arvalid && s_axi_arready;
    // Write commits on the edge where the later of address and data arrives
    assign wr_go   = (aw_held_r || aw_hs) && (w_held_r || w_hs) && !bvalid_r;
    assign wr_slot = slot_of(aw_held_r ? aw_addr_r : s_axi_awaddr);
    assign wr_data = w_held_r ? w_byte_r : s_axi_wdata[7:0];
    assign wr_lane = w_held_r ? w_lane_r : s_axi_wstrb[0];
    assign rd_slot = slot_of(s_axi_araddr);

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    always_comb begin
        aw_held_nxt = aw_held_r;
        aw_addr_nxt = aw_addr_r;
        w_held_nxt  = w_held_r;
        w_byte_nxt  = w_byte_r;
        w_lane_nxt  = w_lane_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        if (aw_hs) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (w_hs) begin
            w_held_nxt = 1'b1;
            w_byte_nxt = s_axi_wdata[7:0];
            w_lane_nxt = s_axi_wstrb[0];
        end
        if (wr_go) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            // Read-only slots accept the write silently
            bresp_nxt   = (wr_slot == imucfg_pkg::SLOT_NONE) ? imucfg_pkg::RESP_SLVERR
                                                              : imucfg_pkg::RESP_OKAY;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 12'h000;
            w_held_r  <= 1'b0;
            w_byte_r  <= 8'h00;
            w_lane_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= 2'h0;
        end else begin
            aw_held_r <= aw_held_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_held_r  <= w_held_nxt;
            w_byte_r  <= w_byte_nxt;
            w_lane_r  <= w_lane_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
        end
    end

    // ------------------------------------------------------------
    // Configuration storage
    // ------------------------------------------------------------
    // Any code is stored as written; decoding it is the sensor path's job
    generate
        for (genvar g = 0; g < imucfg_pkg::NUM_CFG; g++) begin : g_cfg
            always_comb begin
                cfg_nxt[g] = cfg_r[g];
                if (wr_go && wr_lane && wr_slot == 4'(g)) begin
                    cfg_nxt[g] = wr_data & imucfg_pkg::CFG_MASK[g];
                end
            end

            always_ff @(posedge core_clk) begin
                if (!resetn) begin
                    cfg_r[g] <= imucfg_pkg::CFG_RST[g];
                end else begin
                    cfg_r[g] <= cfg_nxt[g];
                end
            end
        end
    endgenerate

    // Field extraction onto the configuration bundle
    always_comb begin
        cfg.temp_dig_en       = cfg_r[0][imucfg_pkg::TEMP_EN_BIT];
        cfg.temp_odr          = cfg_r[0][imucfg_pkg::TEMP_ODR_LSB +: 2];
        cfg.room_temp         = {cfg_r[0][3:0], cfg_r[1]};
        cfg.temp_ana_en       = !cfg_r[12][imucfg_pkg::ANALOG_OFF_BIT];
        cfg.acc_low_power     = cfg_r[2][imucfg_pkg::ACC_LP_BIT];
        cfg.acc_dither        = cfg_r[2][imucfg_pkg::ACC_DITHER_BIT];
        cfg.acc_filt_en       = cfg_r[2][imucfg_pkg::ACC_FILT_BIT];
        cfg.acc_odr           = cfg_r[3][3:0];
        cfg.acc_range         = cfg_r[4][2:0];
        cfg.acc_lpf_cut       = cfg_r[5][imucfg_pkg::ACC_CUT_LSB +: 3];
        cfg.acc_lpf_bypass    = cfg_r[5][imucfg_pkg::ACC_BYP_BIT];
        cfg.gyro_inact_off_en = cfg_r[6][imucfg_pkg::GYRO_INACT_BIT];
        cfg.gyro_filt_en      = cfg_r[6][imucfg_pkg::GYRO_FILT_BIT];
        cfg.gyro_odr          = cfg_r[7][3:0];
        cfg.gyro_lpf_bypass   = cfg_r[8][imucfg_pkg::GYRO_BYP_BIT];
        cfg.gyro_lpf_cut      = cfg_r[8][imucfg_pkg::GYRO_CUT_LSB +: 2];
        cfg.gyro_fs_x         = cfg_r[9][2:0];
        cfg.gyro_fs_y         = cfg_r[10][2:0];
        cfg.gyro_fs_z         = cfg_r[11][2:0];
    end

    // ------------------------------------------------------------
    // Gyroscope shutdown on inactivity
    // ------------------------------------------------------------
    // Sticky while enabled; clearing the enable wakes the gyro again
    always_comb begin
        gyro_off_nxt = cfg.gyro_inact_off_en && (gyro_off_r || inactivity_evt);
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            gyro_off_r <= 1'b0;
        end else begin
            gyro_off_r <= gyro_off_nxt;
        end
    end

    assign gyro_power_down = gyro_off_r;

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    // The pop happens at address acceptance, so a read is never replayed
    assign q_pop = ar_hs && rd_slot == imucfg_pkg::SLOT_SAMPLE;

    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (ar_hs) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = imucfg_pkg::RESP_OKAY;
            rdata_nxt  = 32'h0000_0000;
            if (rd_slot == imucfg_pkg::SLOT_SAMPLE) begin
                rdata_nxt[7:0] = q_empty ? 8'h00 : q_head;
            end else if (rd_slot == imucfg_pkg::SLOT_STATUS) begin
                rdata_nxt[imucfg_pkg::STAT_GYRO_OFF] = gyro_off_r;
                rdata_nxt[imucfg_pkg::STAT_Q_EMPTY]  = q_empty;
            end else if (rd_slot == imucfg_pkg::SLOT_NONE) begin
                rresp_nxt = imucfg_pkg::RESP_SLVERR;
            end else begin
                rdata_nxt[7:0] = cfg_r[rd_slot];
            end
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= 2'h0;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r  <= rdata_nxt;
            rresp_r  <= rresp_nxt;
        end
    end

    imucfg_sample_queue #(
        .DEPTH    (Q_DEPTH)
    ) u_queue (
        .core_clk (core_clk),
        .resetn   (resetn),
        .in_valid (sample_valid),
        .in_data  (sample_data),
        .in_ready (sample_ready),
        .pop      (q_pop),
        .head     (q_head),
        .empty    (q_empty)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_wr_slot(logic [3:0] s);
        wr_go && wr_lane && wr_slot == s;
    endsequence

    property p_sample_wr_ignored;
        @(posedge core_clk) disable iff (!resetn)
        s_wr_slot(imucfg_pkg::SLOT_SAMPLE) |=> $stable(cfg) && s_axi_bresp == 2'b00;
    endproperty
    a_sample_wr_ignored: assert property (p_sample_wr_ignored) else $error("sample write had effect");

    property p_reset_temp;
        @(posedge core_clk)
        !resetn |=> cfg.temp_dig_en && cfg.temp_odr == 2'b11 && !cfg.temp_ana_en;
    endproperty
    a_reset_temp: assert property (p_reset_temp) else $error("temp reset values wrong");

    property p_analog_inverted;
        @(posedge core_clk) disable iff (!resetn)
        s_wr_slot(4'd12) |=> cfg.temp_ana_en == !$past(wr_data[2]);
    endproperty
    a_analog_inverted: assert property (p_analog_inverted) else $error("analog enable polarity");

    property p_room_temp;
        @(posedge core_clk) disable iff (!resetn)
        s_wr_slot(4'd1) |=> cfg.room_temp[7:0] == $past(wr_data) && $stable(cfg.room_temp[11:8]);
    endproperty
    a_room_temp: assert property (p_room_temp) else $error("room temp low byte lost");

    property p_reset_accel;
        @(posedge core_clk)
        !resetn |=> cfg.acc_filt_en && cfg.acc_range == 3'b010 && cfg.acc_lpf_cut == 3'b001
                    && !cfg.acc_low_power && cfg.acc_odr == 4'h0;
    endproperty
    a_reset_accel: assert property (p_reset_accel) else $error("accel reset values wrong");

    property p_code_kept;
        @(posedge core_clk) disable iff (!resetn)
        s_wr_slot(4'd3) |=> cfg.acc_odr == $past(wr_data[3:0]);
    endproperty
    a_code_kept: assert property (p_code_kept) else $error("rate code not stored");

    sequence s_inact_armed;
        cfg.gyro_inact_off_en && inactivity_evt;
    endsequence

    property p_gyro_off;
        @(posedge core_clk) disable iff (!resetn)
        s_inact_armed ##1 cfg.gyro_inact_off_en[*2] |-> gyro_power_down;
    endproperty
    a_gyro_off: assert property (p_gyro_off) else $error("gyro not powered down");

    property p_gyro_runs;
        @(posedge core_clk) disable iff (!resetn)
        !cfg.gyro_inact_off_en |=> !gyro_power_down;
    endproperty
    a_gyro_runs: assert property (p_gyro_runs) else $error("gyro off while disabled");

    property p_sample_read;
        @(posedge core_clk) disable iff (!resetn)
        q_pop && !q_empty |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(q_head);
    endproperty
    a_sample_read: assert property (p_sample_read) else $error("sample read data wrong");

    property p_reset_gyro;
        @(posedge core_clk)
        !resetn |=> cfg.gyro_fs_x == 3'b110 && cfg.gyro_fs_z == 3'b110 && cfg.gyro_filt_en;
    endproperty
    a_reset_gyro: assert property (p_reset_gyro) else $error("gyro reset values wrong");
endmodule

// ---- tb/imucfg_sample_src.sv ----
// Sample producer model feeding the buffered-sample input of the bank
`timescale 1ns/100ps
module imucfg_sample_src (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       go,
    input  wire logic [7:0] base,
    output logic            sample_valid,
    output logic [7:0]      sample_data,
    input  wire logic       sample_ready
);
    logic [1:0] cnt_r;

    // ------------------------------------------------------------
    // Burst of three bytes, held until taken
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        if (!resetn) begin
            sample_valid <= 1'b0;
            sample_data  <= 8'h00;
            cnt_r        <= 2'h0;
        end else if (sample_valid && sample_ready) begin
            cnt_r <= cnt_r + 2'h1;
            // Idle data inverted so a stale byte never looks valid
            sample_data  <= (cnt_r == 2'h2) ? ~sample_data : sample_data + 8'h01;
            sample_valid <= (cnt_r != 2'h2);
        end else if (go && !sample_valid) begin
            sample_valid <= 1'b1;
            sample_data  <= base;
            cnt_r        <= 2'h0;
        end
    end
endmodule

// ---- tb/imucfg_regs_tb.sv ----
// Self-checking bench of the sensor configuration register bank
`timescale 1ns/100ps
module imucfg_regs_tb;
    logic        core_clk = 1'b0, resetn = 1'b0, go = 1'b0, inactivity_evt = 1'b0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_d;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic        sample_valid, sample_ready, gyro_power_down;
    logic [7:0]  sample_data, v, b = 8'h00;
    logic [7:0]  sh [13];
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic [31:0] seed;
    imucfg_pkg::imucfg_cfg_t cfg;
    int          fail_count = 0, n_checks = 0, i;

    always #20 core_clk = ~core_clk;

    imucfg_regs #(.Q_DEPTH(4)) imucfg_regs_i (.core_clk, .resetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .sample_valid, .sample_data, .sample_ready, .inactivity_evt,
        .gyro_power_down, .cfg);
    imucfg_sample_src imucfg_sample_src_i (.core_clk, .resetn, .go, .base(b), .sample_valid,
        .sample_data, .sample_ready);

    // ------------------------------------------------------------
    // Bus cycles, byte address is four times the index
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] ix, input logic [7:0] d);
        @(posedge core_clk);
        s_axi_awaddr  <= {2'b00, ix, 2'b00};
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        // No cycle budget here; only the hang guard ends a stuck write
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ix);
        @(posedge core_clk);
        s_axi_araddr  <= {2'b00, ix, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd_d = s_axi_rdata;
        rsp  = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Expected decoded bundle, rebuilt from the shadow bytes field by field
    function automatic imucfg_pkg::imucfg_cfg_t exp_cfg();
        return {sh[0][7], sh[0][5:4], sh[0][3:0], sh[1], ~sh[12][2], sh[2][7], sh[2][6],
                sh[2][0], sh[3][3:0], sh[4][2:0], sh[5][7:5], sh[5][3], sh[6][4], sh[6][0],
                sh[7][3:0], sh[8][4], sh[8][3:2], sh[9][2:0], sh[10][2:0], sh[11][2:0]};
    endfunction

    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #(40 * 20000);
        fail_count++;
        close_out();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h9781d633;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        for (i = 0; i < 13; i++) begin
            rd(imucfg_pkg::CFG_IDX[i]);
            chk(rd_d, {24'h0, imucfg_pkg::CFG_RST[i]});
            sh[i] = imucfg_pkg::CFG_RST[i];
        end
        chk(cfg, exp_cfg());
        chk({31'h0, cfg.temp_ana_en}, 32'h0);
        // Random values, reserved bits must drop out
        for (i = 0; i < 26; i++) begin
            v = 8'($random(seed));
            wr(imucfg_pkg::CFG_IDX[i % 13], v);
            rd(imucfg_pkg::CFG_IDX[i % 13]);
            chk(rd_d, {24'h0, v & imucfg_pkg::CFG_MASK[i % 13]});
            sh[i % 13] = v & imucfg_pkg::CFG_MASK[i % 13];
        end
        // A write with its low byte lane off must store nothing
        s_axi_wstrb <= 4'h0;
        wr(imucfg_pkg::IDX_ACC_RANGE, ~sh[4]);
        s_axi_wstrb <= 4'h1;
        chk(cfg, exp_cfg());
        wr(imucfg_pkg::IDX_TEMP_CTRL, 8'h3a);
        wr(imucfg_pkg::IDX_ROOM_TEMP_LO, 8'h5c);
        wr(imucfg_pkg::IDX_TEMP_ANALOG, 8'h00);
        chk({20'h0, cfg.room_temp}, 32'ha5c);
        chk({29'h0, cfg.temp_dig_en, cfg.temp_odr}, 32'h3);
        chk({31'h0, cfg.temp_ana_en}, 32'h1);
        // Every rate code on both sensors
        for (i = 0; i < 16; i++) begin
            wr(imucfg_pkg::IDX_ACC_RATE, i[7:0]);
            wr(imucfg_pkg::IDX_GYRO_RATE, ~i[7:0]);
            chk({24'h0, cfg.acc_odr, cfg.gyro_odr}, {24'h0, i[3:0], ~i[3:0]});
        end
        rd(8'h01);
        chk({30'h0, rsp}, {30'h0, imucfg_pkg::RESP_SLVERR});
        // Queued bytes come back oldest first, a write cannot disturb them
        b  = 8'($random(seed));
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        repeat (6) @(posedge core_clk);
        wr(imucfg_pkg::IDX_SAMPLE_PORT, ~b);
        chk({30'h0, rsp}, {30'h0, imucfg_pkg::RESP_OKAY});
        for (i = 0; i < 4; i++) begin
            rd(imucfg_pkg::IDX_SAMPLE_PORT);
            chk(rd_d, (i < 3) ? {24'h0, b + i[7:0]} : 32'h0);
        end
        // Inactivity shuts the gyro only when armed
        for (i = 0; i < 2; i++) begin
            wr(imucfg_pkg::IDX_GYRO_MODE, (i == 1) ? 8'h11 : 8'h01);
            inactivity_evt <= 1'b1;
            @(posedge core_clk);
            inactivity_evt <= 1'b0;
            repeat (2) @(posedge core_clk);
            chk({31'h0, gyro_power_down}, i);
        end
        wr(imucfg_pkg::IDX_GYRO_MODE, 8'h01);
        repeat (2) @(posedge core_clk);
        chk({31'h0, gyro_power_down}, 32'h0);
        close_out();
    end
endmodule
